// ### cpsw_defs.vh
// constants for the program counter and status word block
// assumes inclusion by bare name from the design files of this block
`ifndef CPSW_DEFS_VH
`define CPSW_DEFS_VH
// register indices on the software port
`define CPSW_ADDR_SW_LOWER  4'h0
`define CPSW_ADDR_SW_UPPER  4'h1
`define CPSW_ADDR_PC_LOW    4'h2
`define CPSW_ADDR_PC_MID    4'h3
`define CPSW_ADDR_PC_HIGH   4'h4
`define CPSW_ADDR_REGMAP    4'h5
// status word bit positions (lower half)
`define CPSW_BIT_CARRY      0
`define CPSW_BIT_ZERO_RSVD  1
`define CPSW_BIT_PARITY     2
`define CPSW_BIT_IE         3
`define CPSW_BIT_AUX        4
`define CPSW_BIT_RSS        5
`define CPSW_BIT_ZERO       6
`define CPSW_BIT_SIGN       7
// upper half positions, counted within the whole 16-bit word
`define CPSW_BIT_BANK_LO    12
`define CPSW_BIT_USER       15
// reset values
`define CPSW_RST_SW         16'h0000
`define CPSW_RST_PC_HIGH    4'h0
// flag update source selects
`define CPSW_PV_NONE        2'h0
`define CPSW_PV_PARITY      2'h1
`define CPSW_PV_OVERFLOW    2'h2
`endif

// ### cpsw_flag_calc.v
// result flag calculator: parity, overflow, zero, sign; carries come in as inputs
// assumes a combinational result from the alu of the same clock
`include "cpsw_defs.vh"
module cpsw_flag_calc (
    input  wire [15:0] res,        // operation result
    input  wire        wide,       // 16-bit operation
    input  wire        shift16,    // 16-bit shift, parity on low byte
    input  wire        c_msb_out,  // carry out of msb
    input  wire        c_msb_in,   // carry into msb
    output wire        parity,     // even count of ones
    output wire        overflow,   // two's complement overflow
    output wire        zero,       // all zero result
    output wire        sign        // result msb
);
    wire [15:0] pmask;
    // parity over byte for 16-bit shifts and 8-bit ops
    assign pmask    = (wide && !shift16) ? 16'hffff : 16'h00ff;
    assign parity   = ~^(res & pmask);
    assign overflow = c_msb_out ^ c_msb_in;
    assign zero     = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
    assign sign     = wide ? res[15] : res[7];
endmodule

// ### cpsw_int_gate.v
// interrupt acceptance gate driven by the enable flag
// assumes mask flags and priority resolved by the interrupt controller
module cpsw_int_gate (
    input  wire ie,           // interrupt enable flag
    input  wire nmi_req,      // non-maskable request
    input  wire macro_req,    // unmasked macro service request
    input  wire mask_req,     // maskable request, mask and priority passed
    output wire accept_nmi,   // accept non-maskable
    output wire accept_macro, // accept macro service
    output wire accept_mask   // accept vectored maskable
);
    // nmi and macro service pass regardless of the enable flag
    assign accept_nmi   = nmi_req;
    assign accept_macro = macro_req & ~nmi_req;
    assign accept_mask  = ie & mask_req & ~nmi_req & ~macro_req;
endmodule

// ### cpsw_core.v
// program counter and status word registers of the cpu
// assumes a sequencer on clk_sys issuing one-cycle control strobes
`include "cpsw_defs.vh"
module cpsw_core #(
    parameter PC_W = 20            // program counter width
) (
    input  wire             clk_sys,      // system clock, 20 MHz
    input  wire             rstn,         // async reset, active low
    // program counter control
    input  wire             fetch_en,     // instruction bytes fetched
    input  wire [2:0]       fetch_cnt,    // bytes fetched
    input  wire             branch_en,    // branch taken
    input  wire [PC_W-1:0]  branch_addr,  // immediate or register target
    input  wire             vec_load,     // reset vector word valid
    input  wire [15:0]      vec_word,     // word at addresses 0 and 1
    output reg  [PC_W-1:0]  pc_q,         // program counter
    // result flag updates
    input  wire [15:0]      res,          // operation result
    input  wire             res_wide,     // 16-bit result
    input  wire             res_shift16,  // 16-bit shift
    input  wire             upd_zs,       // update zero and sign
    input  wire             upd_cy,       // update carry
    input  wire             cy_in,        // new carry value
    input  wire             upd_ac,       // update aux carry
    input  wire             ac_in,        // carry or borrow at bit 3
    input  wire [1:0]       upd_pv,       // parity/overflow source
    input  wire             c_msb_out,    // carry out of msb
    input  wire             c_msb_in,     // carry into msb
    // bit manipulation and instruction control
    input  wire             bit_wr,       // single-bit write
    input  wire [3:0]       bit_sel,      // bit within status word
    input  wire             bit_val,      // value written
    input  wire             ei_instr,     // enable interrupts
    input  wire             di_instr,     // disable interrupts
    input  wire             bank_instr,   // bank select instruction
    input  wire [2:0]       bank_num,     // chosen bank
    // save and restore
    input  wire             save_sw,      // push or copy to pair
    input  wire             ctx_mode,     // context switching in use
    input  wire             restore_sw,   // return instruction
    input  wire [15:0]      restore_data, // popped word
    output wire [15:0]      stack_data,   // word to stack
    output wire             stack_push,   // push strobe
    output wire [15:0]      pair_data,    // word to fourth register pair
    output wire             pair_write,   // pair write strobe
    // interrupts
    input  wire             nmi_req,      // non-maskable request
    input  wire             macro_req,    // macro service request
    input  wire             mask_req,     // maskable request
    output wire             accept_nmi,   // non-maskable accepted
    output wire             accept_macro, // macro service accepted
    output wire             accept_mask,  // maskable accepted
    // flags to branch and register logic
    output wire             carry_flag,   // carry
    output wire             pv_flag,      // parity/overflow
    output wire             zero_flag,    // zero
    output wire             sign_flag,    // sign
    output wire [2:0]       bank_sel,     // register bank
    output wire [2:0]       reg_a,        // register index for a
    output wire [2:0]       reg_x,        // register index for x
    output wire [2:0]       reg_b,        // register index for b
    output wire [2:0]       reg_c,        // register index for c
    output wire [1:0]       pair_ax,      // pair index for ax
    output wire [1:0]       pair_bc,      // pair index for bc
    // software register port
    input  wire [3:0]       reg_addr,     // register index
    input  wire [7:0]       reg_wdata,    // write data
    input  wire             reg_wr,       // write strobe
    input  wire             reg_rd,       // read strobe
    output reg  [7:0]       reg_rdata_q   // read data, next cycle
);
    reg         rst_s1_q;
    reg         rst_s2_q;
    reg  [15:0] sw_q;
    reg  [15:0] sw_d;
    wire        f_par;
    wire        f_ovf;
    wire        f_zero;
    wire        f_sign;

    // reset release through two flip-flops
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    cpsw_flag_calc u_flags (
        .res       (res),
        .wide      (res_wide),
        .shift16   (res_shift16),
        .c_msb_out (c_msb_out),
        .c_msb_in  (c_msb_in),
        .parity    (f_par),
        .overflow  (f_ovf),
        .zero      (f_zero),
        .sign      (f_sign)
    );

    cpsw_int_gate u_gate (
        .ie           (sw_q[`CPSW_BIT_IE]),
        .nmi_req      (nmi_req),
        .macro_req    (macro_req),
        .mask_req     (mask_req),
        .accept_nmi   (accept_nmi),
        .accept_macro (accept_macro),
        .accept_mask  (accept_mask)
    );

    // program counter: vector, branch, then fetch advance
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pc_q <= {PC_W{1'b0}};
        end else if (!rst_s2_q) begin
            pc_q <= {PC_W{1'b0}};
        end else if (vec_load) begin
            pc_q <= {`CPSW_RST_PC_HIGH, vec_word};
        end else if (branch_en) begin
            pc_q <= branch_addr;
        end else if (fetch_en) begin
            pc_q <= pc_q + {{(PC_W-3){1'b0}}, fetch_cnt};
        end
    end

    // status word next value; untouched bits hold
    always @* begin
        sw_d = sw_q;
        if (upd_cy)
            sw_d[`CPSW_BIT_CARRY] = cy_in;
        if (upd_ac)
            sw_d[`CPSW_BIT_AUX] = ac_in;
        if (upd_zs) begin
            sw_d[`CPSW_BIT_ZERO] = f_zero;
            sw_d[`CPSW_BIT_SIGN] = f_sign;
        end
        case (upd_pv)
            `CPSW_PV_PARITY:   sw_d[`CPSW_BIT_PARITY] = f_par;
            `CPSW_PV_OVERFLOW: sw_d[`CPSW_BIT_PARITY] = f_ovf;
            default:           sw_d[`CPSW_BIT_PARITY] = sw_q[`CPSW_BIT_PARITY];
        endcase
        if (bank_instr)
            sw_d[`CPSW_BIT_BANK_LO+2:`CPSW_BIT_BANK_LO] = bank_num;
        if (bit_wr)
            sw_d[bit_sel] = bit_val;
        if (reg_wr && reg_addr == `CPSW_ADDR_SW_LOWER)
            sw_d[7:0] = reg_wdata;
        if (reg_wr && reg_addr == `CPSW_ADDR_SW_UPPER)
            sw_d[15:8] = reg_wdata;
        if (ei_instr)
            sw_d[`CPSW_BIT_IE] = 1'b1;
        if (di_instr)
            sw_d[`CPSW_BIT_IE] = 1'b0;
        if (restore_sw)
            sw_d = restore_data;
        if (accept_mask)
            sw_d[`CPSW_BIT_IE] = 1'b0;
        sw_d[`CPSW_BIT_ZERO_RSVD] = 1'b0;
    end

    // status word register, cleared by reset
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            sw_q <= `CPSW_RST_SW;
        else if (!rst_s2_q)
            sw_q <= `CPSW_RST_SW;
        else
            sw_q <= sw_d;
    end

    // save path: stack normally, fourth pair under context switching
    assign stack_data = sw_q;
    assign stack_push = save_sw & ~ctx_mode;
    assign pair_data  = sw_q;
    assign pair_write = save_sw & ctx_mode;

    // flags for conditional branches and the bank field
    assign carry_flag = sw_q[`CPSW_BIT_CARRY];
    assign pv_flag    = sw_q[`CPSW_BIT_PARITY];
    assign zero_flag  = sw_q[`CPSW_BIT_ZERO];
    assign sign_flag  = sw_q[`CPSW_BIT_SIGN];
    assign bank_sel   = sw_q[`CPSW_BIT_BANK_LO+2:`CPSW_BIT_BANK_LO];

    // accumulator-style register mapping
    assign reg_a   = sw_q[`CPSW_BIT_RSS] ? 3'h5 : 3'h1;
    assign reg_x   = sw_q[`CPSW_BIT_RSS] ? 3'h4 : 3'h0;
    assign reg_b   = sw_q[`CPSW_BIT_RSS] ? 3'h7 : 3'h3;
    assign reg_c   = sw_q[`CPSW_BIT_RSS] ? 3'h6 : 3'h2;
    assign pair_ax = sw_q[`CPSW_BIT_RSS] ? 2'h2 : 2'h0;
    assign pair_bc = sw_q[`CPSW_BIT_RSS] ? 2'h3 : 2'h1;

    // read port, data the cycle after the strobe
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CPSW_ADDR_SW_LOWER: reg_rdata_q <= sw_q[7:0];
                `CPSW_ADDR_SW_UPPER: reg_rdata_q <= {sw_q[15:12], 4'h0};
                `CPSW_ADDR_PC_LOW:   reg_rdata_q <= pc_q[7:0];
                `CPSW_ADDR_PC_MID:   reg_rdata_q <= pc_q[15:8];
                `CPSW_ADDR_PC_HIGH:  reg_rdata_q <= {4'h0, pc_q[19:16]};
                `CPSW_ADDR_REGMAP:   reg_rdata_q <= {2'h0, pair_ax, 1'b0, reg_a};
                default:             reg_rdata_q <= 8'h00;
            endcase
        end
    end
endmodule

// ### cpsw_properties.sv
// port assertions for the program counter and status word block
// assumes binding onto cpsw_core; one clock, reset active low
module cpsw_properties #(
    parameter PC_W = 20                 // program counter width
) (
    input wire              clk_sys,    // system clock
    input wire              rstn,       // reset, active low
    input wire              fetch_en,   // bytes fetched
    input wire [2:0]        fetch_cnt,  // byte count
    input wire              branch_en,  // branch taken
    input wire [PC_W-1:0]   branch_addr,// branch target
    input wire              vec_load,   // reset vector valid
    input wire [15:0]       vec_word,   // reset vector
    input wire [PC_W-1:0]   pc_q,       // program counter
    input wire              save_sw,    // save request
    input wire              ctx_mode,   // context switching
    input wire [15:0]       stack_data, // status word
    input wire              stack_push, // push strobe
    input wire              pair_write, // pair strobe
    input wire              nmi_req,    // non-maskable request
    input wire              macro_req,  // macro service request
    input wire              mask_req,   // maskable request
    input wire              accept_mask,// maskable accepted
    input wire              bank_instr, // bank select
    input wire [2:0]        bank_num,   // chosen bank
    input wire [2:0]        bank_sel,   // bank field
    input wire [2:0]        reg_a,      // index for a
    input wire [1:0]        pair_ax,    // index for ax
    input wire              bit_wr,     // single-bit write
    input wire              reg_wr,     // byte write
    input wire              restore_sw  // restore strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    // edges since release; the block only acts from the third
    logic [1:0] up_q;
    always @(posedge clk_sys or negedge rstn)
        if (!rstn)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    wire live = (up_q == 2'h3);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_pc_fetch_adv: assert property (
        live && fetch_en && !branch_en && !vec_load |=> pc_q == $past(pc_q) + $past(fetch_cnt))
        else $error("pc did not advance by fetch count");
    a_pc_branch: assert property (
        live && branch_en && !vec_load |=> pc_q == $past(branch_addr))
        else $error("pc did not load branch target");
    a_pc_vector: assert property (
        live && vec_load |=> pc_q == PC_W'($past(vec_word)))
        else $error("pc did not load reset vector");
    a_save_stack: assert property (save_sw && !ctx_mode |-> stack_push && !pair_write)
        else $error("status word not pushed");
    a_save_pair: assert property (save_sw && ctx_mode |-> pair_write && !stack_push)
        else $error("status word not copied to pair");
    a_mask_gate: assert property (
        accept_mask == (mask_req && stack_data[3] && !nmi_req && !macro_req))
        else $error("maskable acceptance wrong");
    a_accept_ie_clr: assert property (live && accept_mask |=> !stack_data[3])
        else $error("enable flag kept after accept");
    a_bank_load: assert property (
        live && bank_instr && !bit_wr && !reg_wr && !restore_sw |=> bank_sel == $past(bank_num))
        else $error("bank field not loaded");
    a_set_map: assert property (
        reg_a == (stack_data[5] ? 3'h5 : 3'h1) && pair_ax == (stack_data[5] ? 2'h2 : 2'h0))
        else $error("register set map wrong");
endmodule
bind cpsw_core cpsw_properties #(.PC_W(PC_W)) u_props (
    .clk_sys, .rstn, .fetch_en, .fetch_cnt, .branch_en, .branch_addr, .vec_load, .vec_word,
    .pc_q, .save_sw, .ctx_mode, .stack_data, .stack_push, .pair_write, .nmi_req, .macro_req,
    .mask_req, .accept_mask, .bank_instr, .bank_num, .bank_sel, .reg_a, .pair_ax, .bit_wr,
    .reg_wr, .restore_sw
);

// ### tb_cpu_program_counter_status_word.sv
// self-checking bench for the program counter and status word block
// assumes cpsw_core with its checker bound, 50 ns clock
module tb_cpu_program_counter_status_word;
    timeunit 1ns;
    timeprecision 100ps;
    // inputs, quiet at time zero
    logic clk_sys = 0, rstn = 0, fetch_en = 0, branch_en = 0, vec_load = 0, res_wide = 0;
    logic res_shift16 = 0, upd_zs = 0, upd_cy = 0, cy_in = 0, upd_ac = 0, ac_in = 0;
    logic c_msb_out = 0, c_msb_in = 0, bit_wr = 0, bit_val = 0, ei_instr = 0, di_instr = 0;
    logic bank_instr = 0, save_sw = 0, ctx_mode = 0, restore_sw = 0, nmi_req = 0;
    logic macro_req = 0, mask_req = 0, reg_wr = 0, reg_rd = 0;
    logic [2:0]  fetch_cnt = 0, bank_num = 0;
    logic [19:0] branch_addr = 0;
    logic [15:0] vec_word = 0, res = 0, restore_data = 0;
    logic [1:0]  upd_pv = 0;
    logic [3:0]  bit_sel = 0, reg_addr = 0;
    logic [7:0]  reg_wdata = 0;
    wire  [19:0] pc_q;
    wire  [15:0] stack_data, pair_data;
    wire  [7:0]  reg_rdata_q;
    wire  [2:0]  bank_sel, reg_a, reg_x, reg_b, reg_c;
    wire  [1:0]  pair_ax, pair_bc;
    wire         stack_push, pair_write, accept_nmi, accept_macro, accept_mask;
    wire         carry_flag, pv_flag, zero_flag, sign_flag;
    int          num_errors = 0, samples_checked = 0, cycles = 0;
    cpsw_core DUT (
        .clk_sys, .rstn, .fetch_en, .fetch_cnt, .branch_en, .branch_addr, .vec_load, .vec_word,
        .pc_q, .res, .res_wide, .res_shift16, .upd_zs, .upd_cy, .cy_in, .upd_ac, .ac_in, .upd_pv,
        .c_msb_out, .c_msb_in, .bit_wr, .bit_sel, .bit_val, .ei_instr, .di_instr, .bank_instr,
        .bank_num, .save_sw, .ctx_mode, .restore_sw, .restore_data, .stack_data, .stack_push,
        .pair_data, .pair_write, .nmi_req, .macro_req, .mask_req, .accept_nmi, .accept_macro,
        .accept_mask, .carry_flag, .pv_flag, .zero_flag, .sign_flag, .bank_sel, .reg_a, .reg_x,
        .reg_b, .reg_c, .pair_ax, .pair_bc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q
    );
    // clock, and a cycle ceiling against hangs
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    // strobes set by the caller drop after the next edge
    task automatic step();
        @(posedge clk_sys);
        {fetch_en, branch_en, vec_load, upd_zs, upd_cy, upd_ac, bit_wr, ei_instr} <= '0;
        {di_instr, bank_instr, save_sw, restore_sw, reg_wr, reg_rd, upd_pv} <= '0;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        step();
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        step();
        chk(what, exp, reg_rdata_q);
    endtask
    // one flag update: zs cy ac pv[1:0] wide sh16 mo mi cyin acin
    task automatic flg(input logic [10:0] c, input logic [15:0] r, input logic [7:0] exp);
        @(posedge clk_sys);
        {upd_zs, upd_cy, upd_ac, upd_pv, res_wide, res_shift16, c_msb_out, c_msb_in, cy_in,
            ac_in, res} <= {c, r};
        step();
        chk("status lower", exp, stack_data[7:0]);
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("status reset", 20'h0_0000, stack_data);
        rd("upper reset", 4'h1, 8'h00);
        @(posedge clk_sys);
        {vec_load, vec_word} <= {1'b1, 16'hA5C3};
        step();
        chk("pc vector", 20'h0_A5C3, pc_q);
        rd("pc high", 4'h4, 8'h00);
        rd("pc low", 4'h2, 8'hC3);
        rd("pc mid", 4'h3, 8'hA5);
        @(posedge clk_sys);
        {branch_en, branch_addr, fetch_en, fetch_cnt} <= {1'b1, 20'hF_FFFE, 1'b1, 3'h2};
        step();
        chk("pc branch", 20'hF_FFFE, pc_q);
        @(posedge clk_sys);
        {fetch_en, fetch_cnt} <= {1'b1, 3'h7};
        @(posedge clk_sys);
        fetch_cnt <= 3'h4;
        step();
        chk("pc wrap", 20'h0_0009, pc_q);
        wr(4'h0, 8'hFD);
        wr(4'h1, 8'hFF);
        rd("lower", 4'h0, 8'hFD);
        rd("upper", 4'h1, 8'hF0);
        chk("map one", 16'hB3EB, {reg_a, reg_x, reg_b, reg_c, pair_ax, pair_bc});
        rd("reg map", 4'h5, 8'h25);
        @(posedge clk_sys);
        mask_req <= 1'b1;
        #1 chk("mask accept", 1'b1, accept_mask);
        step();
        chk("ie cleared", {1'b0, 1'b0}, {stack_data[3], accept_mask});
        @(posedge clk_sys);
        {nmi_req, macro_req} <= 2'h2;
        #1 chk("nmi", 2'h2, {accept_nmi, accept_macro});
        @(posedge clk_sys);
        {nmi_req, macro_req} <= 2'h1;
        #1 chk("macro", 2'h1, {accept_nmi, accept_macro});
        @(posedge clk_sys);
        {nmi_req, macro_req, mask_req, ei_instr} <= 4'h1;
        step();
        chk("ie set", 1'b1, stack_data[3]);
        @(posedge clk_sys);
        di_instr <= 1'b1;
        step();
        chk("ie clear", 1'b0, stack_data[3]);
        flg(11'h400, 16'hFF00, 8'h75);
        flg(11'h420, 16'h8000, 8'hB5);
        flg(11'h400, 16'h0100, 8'h75);
        flg(11'h400, 16'h0080, 8'hB5);
        flg(11'h040, 16'h0007, 8'hB1);
        flg(11'h040, 16'h0003, 8'hB5);
        flg(11'h070, 16'h0107, 8'hB1);
        flg(11'h084, 16'h0000, 8'hB5);
        flg(11'h08C, 16'h0000, 8'hB1);
        flg(11'h300, 16'h0000, 8'hA0);
        flg(11'h303, 16'h0000, 8'hB1);
        chk("branch flags", 4'h9, {carry_flag, pv_flag, zero_flag, sign_flag});
        @(posedge clk_sys);
        {bit_wr, bit_sel, bit_val} <= {1'b1, 4'hF, 1'b0};
        step();
        rd("user flag", 4'h1, 8'h70);
        @(posedge clk_sys);
        {bank_instr, bank_num} <= {1'b1, 3'h3};
        step();
        chk("bank", 3'h3, bank_sel);
        @(posedge clk_sys);
        {bit_wr, bit_sel, bit_val} <= {1'b1, 4'h5, 1'b0};
        step();
        chk("map zero", 16'h21A1, {reg_a, reg_x, reg_b, reg_c, pair_ax, pair_bc});
        @(posedge clk_sys);
        {save_sw, ctx_mode} <= 2'h2;
        #1 chk("push", 17'h1_3F91, {stack_push, stack_data});
        @(posedge clk_sys);
        ctx_mode <= 1'b1;
        #1 chk("pair", 17'h1_3F91, {pair_write, pair_data});
        @(posedge clk_sys);
        {save_sw, ctx_mode, restore_sw, restore_data} <= {3'h1, 16'h4A6E};
        step();
        rd("restore lower", 4'h0, 8'h6C);
        rd("restore upper", 4'h1, 8'h40);
        wr(4'h9, 8'hFF);
        rd("unmapped", 4'h9, 8'h00);
        rd("lower kept", 4'h0, 8'h6C);
        stop_test();
    end
endmodule
